/* verilog/clock_source_startup_control.sv */
// Clock source selection, start-up timing and domain clock gating.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "clk_startup_cfg.svh"
module clock_source_startup_control
  import clk_startup_pkg::*;
#(
  parameter logic [14:0] WD_LONG_CYCLES   = `WD_LONG_CYCLES,
  parameter logic [14:0] XTAL_WAKE_CYCLES = `XTAL_WAKE_CYCLES
) (
  input  wire logic       ref_clk,              // System clock, 10 MHz.
  input  wire logic       sys_rst,              // Asynchronous reset, active high.
  input  wire logic [3:0] clock_source_select,  // Fuse field, sampled after reset.
  input  wire logic [1:0] startup_time_select,  // Fuse field, sampled after reset.
  input  wire logic       reset_pin_disable,    // Fuse, zero when programmed.
  input  wire logic       divide_by_eight_default, // Fuse, zero when programmed.
  input  wire logic [7:0] cal_byte,             // Factory calibration byte.
  input  wire logic [4:0] src_ticks,            // Per-source cycle enables, indexed by source kind.
  input  wire logic       wd_tick,              // Watchdog oscillator cycle enable.
  input  wire logic       sleep_req,            // Sleep instruction pulse from the core.
  input  wire logic       wake_event,           // Synchronous wake request.
  input  wire logic       ext_int_async,        // Raw level of an asynchronously detected interrupt.
  input  wire logic [3:0] addr,                 // Register address.
  input  wire logic [7:0] wdata,                // Register write data.
  input  wire logic       wr_en,                // Register write strobe.
  input  wire logic       rd_en,                // Register read strobe.
  output logic      [7:0] rdata,                // Read data, valid the cycle after rd_en.
  output logic            exec_enable,          // Core may execute instructions.
  output logic            core_clk_en,          // Core clock gate.
  output logic            flash_clk_en,         // Program-memory clock gate.
  output logic            periph_clk_en,        // Peripheral clock gate.
  output logic            adc_clk_en,           // Converter clock gate.
  output logic            core_freeze,          // Freeze register file, status and stack.
  output logic            ext_int_wake,         // Asynchronous interrupt detect.
  output logic      [7:0] osc_trim,             // Trim to the internal RC oscillator.
  output logic      [2:0] active_source,        // Decoded clock source kind.
  output logic            prescale_div8,        // Initial divide-by-eight request.
  output logic            config_error          // Reserved fuse code seen.
);

  // ****************************************************************
  // Fuse shadow and decode
  // ****************************************************************
  // The fuse shadow is the only copy of the configuration that logic reads.
  // The fuse pins may move at any time, so nothing else looks at them.
  ctl_state_t  state_q, state_d;
  logic [3:0]  src_sel_q;
  logic [1:0]  sut_q;
  logic        rstdis_q;
  logic        div8_q;
  logic        in_load, in_rst_ck, in_rst_wd, in_run, in_sleep, in_wake;

  // One-hot state flags for the decode and the checks.
  assign in_load   = (state_q == ST_LOAD);
  assign in_rst_ck = (state_q == ST_RST_CK);
  assign in_rst_wd = (state_q == ST_RST_WD);
  assign in_run    = (state_q == ST_RUN);
  assign in_sleep  = (state_q == ST_SLEEP);
  assign in_wake   = (state_q == ST_WAKE);

  // Fuses read as the shipped defaults until the first cycle after reset release.
  // Reading them only here keeps the running clock source fixed.
  // A later fuse change needs a new reset to act.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_sel_q <= `CFG_SRC_SEL_DEFAULT;
      sut_q     <= `CFG_SUT_DEFAULT;
      div8_q    <= `CFG_DIV8_DEFAULT;
      rstdis_q  <= `CFG_RSTDIS_DEFAULT;
    end else if (in_load) begin
      src_sel_q <= clock_source_select;
      sut_q     <= startup_time_select;
      div8_q    <= divide_by_eight_default;
      rstdis_q  <= reset_pin_disable;
    end
  end

  // Source decode; reserved odd codes fall back to the internal 8 MHz oscillator.
  // Falling back keeps the part clocked so software can read the error flag.
  src_kind_t src_kind;
  logic      src_reserved, sut_reserved, internal_src, crystal_src;

  assign src_reserved = !src_sel_q[3] && src_sel_q[0];
  assign sut_reserved = (sut_q == 2'b11);
  assign src_kind     = src_sel_q[3]              ? SRC_XTAL   :
                        (src_sel_q[2:0] == 3'h0)  ? SRC_EXT    :
                        (src_sel_q[2:0] == 3'h4)  ? SRC_RC128K :
                        (src_sel_q[2:0] == 3'h6)  ? SRC_LFXTAL : SRC_RC8M;
  // Group flags used by the length decode.
  assign internal_src = (src_kind == SRC_RC8M) || (src_kind == SRC_RC128K);
  assign crystal_src  = (src_kind == SRC_XTAL) || (src_kind == SRC_LFXTAL);

  // ****************************************************************
  // Start-up lengths
  // ****************************************************************
  // Two lengths: the watchdog part of a reset start and the wake count.
  // The reset clock-cycle count is fixed at fourteen.
  // Crystal wake is long; the other sources settle in six cycles.
  logic [14:0] wd_len, wake_len;
  logic        src_tick;

  // Extra reset delay in watchdog cycles; the reserved code takes the longest one.
  // A disabled reset pin stretches code 00 for the internal oscillators so a programmer can still get in.
  assign wd_len = crystal_src                           ? WD_LONG_CYCLES   :
                  (sut_q == 2'b00 && internal_src && !rstdis_q) ? `WD_SHORT_CYCLES :
                  (sut_q == 2'b00)                      ? 15'h0000         :
                  (sut_q == 2'b01)                      ? `WD_SHORT_CYCLES :
                                                          WD_LONG_CYCLES;
  assign wake_len = crystal_src ? XTAL_WAKE_CYCLES : `WAKE_CK_CYCLES;

  // Only the selected source's ticks time the clock-cycle parts of start-up.
  // A stalled source stalls the start-up instead of being skipped.
  assign src_tick = src_ticks[src_kind];

  // ****************************************************************
  // Start-up counters
  // ****************************************************************
  logic        ck_load, wd_load, ck_done, wd_done;
  logic [14:0] ck_load_val, ck_count, wd_count;

  // Each counter loads on the edge that enters its phase.
  // A tick on that edge is lost to the load, so counting starts with the next tick.
  assign ck_load     = (state_d != state_q) && ((state_d == ST_RST_CK) || (state_d == ST_WAKE));
  assign ck_load_val = (state_d == ST_WAKE) ? wake_len : `RESET_CK_CYCLES;
  assign wd_load     = (state_d != state_q) && (state_d == ST_RST_WD);

  // Both counters are one module; only their load, tick and length differ.
  // Counts cycles of the selected source.
  startup_counter u_ck_cnt (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load     (ck_load),
    .load_val (ck_load_val),
    .tick     (src_tick),
    .count_q  (ck_count),
    .done     (ck_done)
  );

  // Counts watchdog cycles, whatever the system clock source is.
  // Its ticks come from a separate oscillator.
  startup_counter u_wd_cnt (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load     (wd_load),
    .load_val (wd_len),
    .tick     (wd_tick),
    .count_q  (wd_count),
    .done     (wd_done)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Sleep is honoured only when software has armed it.
  // A request with the enable clear leaves the core running.
  logic [2:0] sleep_ctrl_q;
  logic       sleep_en, deep_sleep, wake_any;

  assign sleep_en   = sleep_ctrl_q[`SLEEP_EN_BIT];
  // Standby is handled like power-down.
  assign deep_sleep = (sleep_ctrl_q[1:0] == SLP_PWR_DN) || (sleep_ctrl_q[1:0] == SLP_STDBY);
  assign wake_any   = wake_event || ext_int_async;

  // Reset start runs the cycle count then the watchdog delay; deep sleep wakes
  // through the source cycle count, light sleep resumes at once.
  // Light sleep keeps the oscillator running, so it needs no settling count.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD:   state_d = ST_RST_CK;
      ST_RST_CK: if (ck_done) state_d = ST_RST_WD;
      ST_RST_WD: if (wd_done) state_d = ST_RUN;
      ST_RUN:    if (sleep_req && sleep_en) state_d = ST_SLEEP;
      ST_SLEEP:  if (wake_any) state_d = deep_sleep ? ST_WAKE : ST_RUN;
      ST_WAKE:   if (ck_done) state_d = ST_RUN;
      default:   state_d = ST_LOAD;
    endcase
  end

  // State register.
  // Reset parks it in the load state, so the fuses are read once per reset.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Domain clock gating
  // ****************************************************************
  // Gates decode the next state, so they switch on the edge the state moves.
  // Gate and state therefore never disagree for a cycle.
  // Converter gate covers the peripheral gate, which covers the core gate.
  logic core_en_d, periph_en_d, adc_en_d;
  logic core_en_q, periph_en_q, adc_en_q;
  logic slp_idle, slp_adc;

  assign slp_idle    = (state_d == ST_SLEEP) && (sleep_ctrl_q[1:0] == SLP_IDLE);
  assign slp_adc     = (state_d == ST_SLEEP) && (sleep_ctrl_q[1:0] == SLP_ADC_NR);
  assign core_en_d   = (state_d == ST_RUN);
  assign periph_en_d = core_en_d || slp_idle;
  assign adc_en_d    = periph_en_d || slp_adc;

  // Gates are registered so they change only on a clock edge and never glitch.
  // They start shut, so nothing runs in reset.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_en_q   <= 1'b0;
      periph_en_q <= 1'b0;
      adc_en_q    <= 1'b0;
    end else begin
      core_en_q   <= core_en_d;
      periph_en_q <= periph_en_d;
      adc_en_q    <= adc_en_d;
    end
  end

  // Execution follows the core gate, and program memory is gated with it.
  assign exec_enable   = core_en_q;
  assign core_clk_en   = core_en_q;
  assign flash_clk_en  = core_en_q;
  assign periph_clk_en = periph_en_q;
  assign adc_clk_en    = adc_en_q;
  assign core_freeze   = !core_en_q;
  // No clock in this path, so the detect works with every gate shut.
  assign ext_int_wake  = ext_int_async;

  // ****************************************************************
  // Register port
  // ****************************************************************
  // Three byte registers: trim, read-only status and sleep control.
  // Writes to status or to unused addresses have no effect.
  // Reads answer one cycle late and never stall.
  logic       trim_wr, sleep_wr;
  logic [7:0] status_val, rd_mux;
  logic [7:0] rdata_q;

  assign trim_wr  = wr_en && (addr == `REG_TRIM);
  assign sleep_wr = wr_en && (addr == `REG_SLEEP_CTRL);

  // Trim value; the factory load happens in the cycle after reset release.
  // A software write in that cycle loses to the factory byte.
  osc_trim_reg u_trim (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load_cal (in_load),
    .cal_byte (cal_byte),
    .wr       (trim_wr),
    .wdata    (wdata),
    .trim_q   (osc_trim)
  );

  // Sleep control: mode and enable.
  // Bits above the enable are dropped on write and read back as zero.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_ctrl_q <= 3'h0;
    end else if (sleep_wr) begin
      sleep_ctrl_q <= wdata[2:0];
    end
  end

  // Status packs source, run flag, fuse error and the divide-by-eight fuse.
  // That fuse reads as stored, so a zero there means programmed.
  assign status_val = {2'b00, div8_q, (src_reserved || sut_reserved), in_run, src_kind};
  assign rd_mux     = (addr == `REG_TRIM)       ? osc_trim :
                      (addr == `REG_STATUS)     ? status_val :
                      (addr == `REG_SLEEP_CTRL) ? {5'h00, sleep_ctrl_q} : 8'h00;

  // Read data stand for one cycle only and read zero otherwise.
  // Clearing between reads keeps a stale byte off the bus.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_en ? rd_mux : 8'h00;
    end
  end

  // Outputs taken from the shadow, the decode and the read register.
  assign rdata         = rdata_q;
  assign active_source = src_kind;
  assign prescale_div8 = !div8_q;
  assign config_error  = src_reserved || sut_reserved;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Every check runs on the system clock and rests during reset.
  // Start-up and decode checks.

  decode_ext_src_a: assert property (!in_load && src_sel_q == 4'h0 |-> src_kind == SRC_EXT)
    else $error("External code not decoded as external clock.");
  wake_hold_a: assert property ($rose(in_wake) && !crystal_src |-> !exec_enable [*6])
    else $error("Execution resumed before six wake cycles.");
  wd_phase_end_a: assert property ($fell(in_rst_wd) |-> $past(wd_done) && in_run)
    else $error("Reset delay ended before the watchdog count.");
  wd_count_load_a: assert property ($rose(in_rst_wd) |-> wd_count == wd_len)
    else $error("Watchdog count loaded with the wrong length.");
  long_delay_a: assert property ($rose(in_rst_wd) && sut_q == 2'b10 |-> wd_count == WD_LONG_CYCLES)
    else $error("Code 10 did not give the long reset delay.");
  rstdis_stretch_a: assert property ($rose(in_rst_wd) && internal_src && sut_q == 2'b00 && !rstdis_q
                                     |-> wd_count == `WD_SHORT_CYCLES)
    else $error("Disabled reset pin did not stretch the reset delay.");
  ck_phase_a: assert property ($rose(in_rst_ck) |-> ck_count == `RESET_CK_CYCLES)
    else $error("Reset clock count not fourteen.");
  no_exec_start_a: assert property (in_load || in_rst_ck || in_rst_wd |-> !exec_enable)
    else $error("Execution enabled during reset start-up.");
  ck_phase_end_a: assert property ($fell(in_rst_ck) |-> $past(ck_done) && in_rst_wd)
    else $error("Reset clock count cut short.");
  wake_load_a: assert property ($rose(in_wake) |-> ck_count == wake_len)
    else $error("Wake count loaded with the wrong length.");
  // Trim register checks.
  trim_load_a: assert property (in_load |=> osc_trim == $past(cal_byte))
    else $error("Calibration byte not loaded at reset.");
  trim_write_a: assert property (trim_wr && !in_load |=> osc_trim == $past(wdata))
    else $error("Trim write not applied.");
  // Gating, sleep and fuse shadow checks.
  flash_core_a: assert property (flash_clk_en == core_clk_en && core_freeze == !core_clk_en)
    else $error("Program-memory gate differs from core gate.");
  adc_noise_a: assert property (in_sleep && sleep_ctrl_q[1:0] == SLP_ADC_NR
                                |-> adc_clk_en && !core_clk_en && !periph_clk_en)
    else $error("Converter clock stopped in noise reduction sleep.");
  fuse_hold_a: assert property (!in_load |=> $stable(src_sel_q) && $stable(sut_q))
    else $error("Fuse shadow changed while running.");
  run_gate_a: assert property (in_run |-> core_clk_en && periph_clk_en && adc_clk_en)
    else $error("A domain gate is shut while running.");
  sleep_refuse_a: assert property (in_run && sleep_req && !sleep_en |=> in_run)
    else $error("Sleep entered with the enable clear.");
  light_wake_a: assert property (in_sleep && !deep_sleep && wake_any |=> in_run)
    else $error("Light sleep did not resume at once.");
  idle_gates_a: assert property (in_sleep && sleep_ctrl_q[1:0] == SLP_IDLE |-> periph_clk_en && !core_clk_en)
    else $error("Idle sleep gates wrong.");
  deep_gates_a: assert property (in_sleep && deep_sleep |-> !core_clk_en && !periph_clk_en && !adc_clk_en)
    else $error("Deep sleep left a domain clock running.");

  // Covers for the main scenarios.
  wake_path_c: cover property (in_sleep && deep_sleep ##1 in_wake ##[1:40] in_run);
  long_reset_c: cover property ($rose(in_rst_wd) && wd_len == WD_LONG_CYCLES);
  trim_override_c: cover property (in_run && trim_wr);
  rstdis_stretch_c: cover property ($rose(in_rst_wd) && internal_src && sut_q == 2'b00 && !rstdis_q);
  adc_sleep_c: cover property (in_sleep && sleep_ctrl_q[1:0] == SLP_ADC_NR ##1 in_run);

endmodule

/* include/clk_startup_cfg.svh */
// Constants for the clock source and start-up control block.
`ifndef CLK_STARTUP_CFG_SVH
`define CLK_STARTUP_CFG_SVH

// ****************************************************************
// Fuse defaults, a one reads as unprogrammed
// ****************************************************************
`define CFG_SRC_SEL_DEFAULT   4'b0010
`define CFG_SUT_DEFAULT       2'b10
`define CFG_DIV8_DEFAULT      1'b0
`define CFG_RSTDIS_DEFAULT    1'b1

// ****************************************************************
// Start-up counts, in cycles of the timing oscillator, and the watchdog delays in ms
// ****************************************************************
`define WAKE_CK_CYCLES        15'h0006
`define RESET_CK_CYCLES       15'h000E
`define WD_SHORT_MS           4
`define WD_LONG_MS            64
`define WD_SHORT_CYCLES       15'h0200
`define WD_LONG_CYCLES        15'h2000
`define XTAL_WAKE_CYCLES      15'h4000

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define REG_TRIM              4'h0
`define REG_STATUS            4'h1
`define REG_SLEEP_CTRL        4'h2
`define TRIM_RESET            8'h00
`define SLEEP_MODE_LSB        0
`define SLEEP_EN_BIT          2
`define STAT_SRC_LSB          0
`define STAT_RUN_BIT          3
`define STAT_CFG_ERR_BIT      4
`define STAT_DIV8_BIT         5

`endif

/* include/clk_startup_pkg.sv */
// Types shared by the clock source and start-up control block.
package clk_startup_pkg;

  typedef enum logic [2:0] {
    SRC_EXT    = 3'h0,
    SRC_RC8M   = 3'h1,
    SRC_RC128K = 3'h2,
    SRC_LFXTAL = 3'h3,
    SRC_XTAL   = 3'h4
  } src_kind_t;

  typedef enum logic [1:0] {
    SLP_IDLE   = 2'h0,
    SLP_ADC_NR = 2'h1,
    SLP_PWR_DN = 2'h2,
    SLP_STDBY  = 2'h3
  } sleep_mode_t;

  typedef enum logic [5:0] {
    ST_LOAD   = 6'b00_0001,
    ST_RST_CK = 6'b00_0010,
    ST_RST_WD = 6'b00_0100,
    ST_RUN    = 6'b00_1000,
    ST_SLEEP  = 6'b01_0000,
    ST_WAKE   = 6'b10_0000
  } ctl_state_t;

endpackage

/* verilog/startup_counter.sv */
// Loadable down counter that counts enable ticks of a timing oscillator.
`timescale 1ns/1ns
module startup_counter (
  input  wire logic        ref_clk,   // System clock.
  input  wire logic        sys_rst,   // Asynchronous reset, active high.
  input  wire logic        load,      // Load pulse.
  input  wire logic [14:0] load_val,  // Value to load.
  input  wire logic        tick,      // One-cycle enable from the timing oscillator.
  output logic      [14:0] count_q,   // Remaining ticks.
  output logic             done       // High while the count is zero.
);

  // Count down on each tick and park at zero so a late tick cannot wrap.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 15'h0000;
    end else if (load) begin
      count_q <= load_val;
    end else if (tick && (count_q != 15'h0000)) begin
      count_q <= count_q - 15'h0001;
    end
  end

  // Zero means the timed phase is over.
  assign done = (count_q == 15'h0000);

endmodule

/* verilog/osc_trim_reg.sv */
// Oscillator trim register: calibration load at reset and software override.
`timescale 1ns/1ns
`include "clk_startup_cfg.svh"
module osc_trim_reg (
  input  wire logic       ref_clk,   // System clock.
  input  wire logic       sys_rst,   // Asynchronous reset, active high.
  input  wire logic       load_cal,  // Load the factory byte.
  input  wire logic [7:0] cal_byte,  // Factory calibration byte.
  input  wire logic       wr,        // Software write strobe.
  input  wire logic [7:0] wdata,     // Software write data.
  output logic      [7:0] trim_q     // Trim value to the RC oscillator.
);

  // The factory load owns the register while reset finishes; software comes after.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim_q <= `TRIM_RESET;
    end else if (load_cal) begin
      trim_q <= cal_byte;
    end else if (wr) begin
      trim_q <= wdata;
    end
  end

endmodule

/* testbench/clk_source_model.sv */
// Behavioural clock source that drives the per-source and watchdog cycle enables.
`timescale 1ns/1ns
module clk_source_model (
  input  wire logic       ref_clk,    // System clock.
  input  wire logic       sys_rst,    // Reset, active high.
  input  wire logic       slow,       // Half rate request, taken in reset.
  output logic      [4:0] src_ticks,  // Source cycle enables.
  output logic            wd_tick     // Watchdog cycle enable.
);
  logic rate_q;
  logic ph_q;

  // The rate is only taken while reset holds, because a jump in rate while running is unsafe.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rate_q <= slow;
      ph_q   <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
    end
  end

  // A slow source ticks every other cycle, so the start-up counts stretch in time.
  assign src_ticks = {5{~rate_q | ph_q}};
  // The watchdog oscillator runs on its own; when slow it ticks on the other phase.
  assign wd_tick   = ~rate_q | ~ph_q;
endmodule

/* testbench/clock_source_startup_control_tb_top.sv */
// Self-checking bench for the clock source and start-up control block.
`timescale 1ns/1ns
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, v); end end
module clock_source_startup_control_tb_top;
  import clk_startup_pkg::*;
  localparam int WL = 20;
  localparam logic [6:0] CFG [14] = '{7'b0000_01_1, 7'b0000_10_1, 7'b0010_00_1, 7'b0010_00_0,
    7'b0010_01_1, 7'b0010_10_1, 7'b0100_00_1, 7'b0100_00_0, 7'b0100_10_1, 7'b0001_00_1,
    7'b0010_11_1, 7'b1111_01_1, 7'b0110_00_1, 7'b0000_00_1};
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  clock_source_select = 4'h0;
  logic [3:0]  addr = 4'h0;
  logic [1:0]  startup_time_select = 2'h0;
  logic        reset_pin_disable = 1'b1;
  logic        divide_by_eight_default = 1'b1;
  logic        slow = 1'b0;
  logic        sleep_req = 1'b0;
  logic        wake_event = 1'b0;
  logic        ext_int_async = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  cal_byte = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, osc_trim, rd_v;
  logic [4:0]  src_ticks;
  logic [2:0]  active_source;
  logic        wd_tick, exec_enable, core_clk_en, flash_clk_en, periph_clk_en, adc_clk_en;
  logic        core_freeze, ext_int_wake, prescale_div8, config_error;
  logic [31:0] seed = 32'hd476_f8e2;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          n;

  clock_source_startup_control #(.WD_LONG_CYCLES(15'h0014), .XTAL_WAKE_CYCLES(15'h000a)) u_dut (
    .ref_clk, .sys_rst, .clock_source_select, .startup_time_select, .reset_pin_disable,
    .divide_by_eight_default, .cal_byte, .src_ticks, .wd_tick, .sleep_req, .wake_event,
    .ext_int_async, .addr, .wdata, .wr_en, .rd_en, .rdata, .exec_enable, .core_clk_en,
    .flash_clk_en, .periph_clk_en, .adc_clk_en, .core_freeze, .ext_int_wake, .osc_trim,
    .active_source, .prescale_div8, .config_error);
  clk_source_model u_src (.ref_clk, .sys_rst, .slow, .src_ticks, .wd_tick);

  // ********
  // Reference model and bus helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Reserved odd codes fall back to the 8 MHz oscillator.
  function automatic int kind_of(input int s);
    if (s >= 8) return 4;
    if (s % 2 == 1) return 1;
    return s / 2;
  endfunction
  function automatic int wd_of(input int s, input int u, input int rd);
    if (kind_of(s) >= 3 || u >= 2) return WL;
    if (u == 1 || (rd == 0 && kind_of(s) != 0)) return 512;
    return 0;
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    rd_v = rdata;
  endtask
  task automatic wait_exec(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (exec_enable !== 1'b1 && c < 3000);
    @(posedge ref_clk); // Back on the edge for the next drive.
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int v);
    num_checks++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  // One reset with the given fuses, then the start-up time and decoded state are compared.
  task automatic start(input logic [6:0] c, input logic dv, input int s);
    int k;
    int w;
    logic e;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    {clock_source_select, startup_time_select, reset_pin_disable} <= c;
    divide_by_eight_default <= dv;
    slow <= (s == 2);
    seed = lfsr(seed);
    cal_byte <= seed[7:0];
    repeat (20) @(posedge ref_clk);
    `CHK("defaults", 5'b00110, {active_source, prescale_div8, config_error})
    sys_rst <= 1'b0;
    k = kind_of(c[6:3]);
    w = wd_of(c[6:3], c[2:1], c[0]);
    e = (c[6] == 1'b0 && c[3] == 1'b1) || c[2:1] == 2'b11;
    wait_exec(n);
    chk_rng("startup", 14 * s + w * s + 3 - s, 14 * s + w * s + 3, n);
    `CHK("source", k[2:0], active_source)
    `CHK("cfg_err", e, config_error)
    `CHK("div8", ~dv, prescale_div8)
    `CHK("trim", cal_byte, osc_trim)
    `CHK("gates", 5'b11110, {core_clk_en, flash_clk_en, periph_clk_en, adc_clk_en, core_freeze})
    clock_source_select <= ~c[6:3];
    rd_reg(4'h1);
    `CHK("src_hold", k[2:0], active_source)
    `CHK("status", {2'b00, dv, e, 1'b1, k[2:0]}, rd_v)
    $display("startup test done, code %b", c);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // The longest run is some three thousand cycles, so two milliseconds is ample.
  initial begin
    #2_000_000;
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    start(7'b0000_10_1, 1'b1, 2);
    foreach (CFG[i]) start(CFG[i], i[0], 1);
    seed = lfsr(seed);
    wr_reg(4'h0, seed[7:0]);
    #1;
    `CHK("osc_trim", seed[7:0], osc_trim)
    rd_reg(4'h0);
    `CHK("trim_rd", seed[7:0], rd_v)
    wr_reg(4'h1, 8'hff);
    rd_reg(4'h1);
    `CHK("status_ro", 8'h28, rd_v)
    rd_reg(4'h9);
    `CHK("unmapped", 8'h00, rd_v)
    $display("register test done");
    wr_reg(4'h2, 8'h02);
    @(posedge ref_clk);
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    #1;
    `CHK("no_sleep", 1'b1, core_clk_en)
    for (int m = 0; m < 4; m++) begin
      wr_reg(4'h2, {5'h00, 1'b1, m[1:0]});
      @(posedge ref_clk);
      sleep_req <= 1'b1;
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      #1;
      `CHK("sleep_gates", {2'b00, m == 0, m <= 1, 1'b1}, {core_clk_en, flash_clk_en, periph_clk_en, adc_clk_en, core_freeze})
      @(posedge ref_clk);
      if (m[0]) ext_int_async <= 1'b1;
      else wake_event <= 1'b1;
      #1;
      `CHK("async_int", ext_int_async, ext_int_wake)
      wait_exec(n);
      wake_event <= 1'b0;
      ext_int_async <= 1'b0;
      if (m >= 2) chk_rng("deep_wake", 6, 8, n);
      else chk_rng("light_wake", 1, 2, n);
      $display("sleep test done, mode %0d", m);
    end
    test_done();
  end
endmodule
